/* File: core/btc_map.svh */
// Purpose: Constants of the bridge and temperature correction block
// Assumes: Included by its bare name
// Notes:   Saturation bounds are 40-bit signed to meet the wide datapath
`ifndef BTC_MAP_SVH
`define BTC_MAP_SVH

`define BTC_CMD_BRIDGE_STORED 8'hA2
`define BTC_CMD_BRIDGE_GIVEN  8'hA3
`define BTC_CMD_TEMP_FACTORY  8'hA6
`define BTC_CMD_TEMP_GIVEN    8'hA7
`define BTC_SETUP_ADDR        8'h10
`define BTC_SETUP_RESET       16'h0000
`define BTC_STATUS_SAT_BIT    0

`define BTC_S18_MAX  40'sh000001FFFF
`define BTC_S18_MIN  (-40'sh0000020000)
`define BTC_TSET_MAX 40'sh000000FFFF
`define BTC_U16_MAX  40'sh000000FFFF
`define BTC_HALF     40'sh0000008000
`define BTC_ZERO     40'sh0000000000
`define BTC_SHIFT    15

`endif

/* File: core/btc_pkg.sv */
// Purpose: Types of the bridge and temperature correction block
// Assumes: Constants come from btc_map.svh
// Notes:   One state enum used by the design only; the bench does not import it
package btc_pkg;

  typedef enum logic [2:0] {
    BTC_IDLE,
    BTC_MEAS,
    BTC_DT,
    BTC_K1,
    BTC_K2,
    BTC_Z,
    BTC_OUT
  } btc_state_t;

  typedef struct packed {
    btc_state_t        state;
    logic              busy;
    logic              isTemp;
    logic              measStart;
    logic [15:0]       measConfig;
    logic [15:0]       setup;
    logic signed [17:0] raw;
    logic signed [17:0] tempHold;
    logic signed [17:0] deltaT;
    logic signed [17:0] gainDriftFactor;
    logic signed [17:0] offsetCorrectedBridge;
    logic signed [17:0] interm;
    logic              sat;
    logic              resultValid;
    logic [15:0]       resultData;
    logic signed [17:0] resultRaw;
    logic              resultIsTemp;
    logic [7:0]        resultStatus;
  } btc_regs_t;

endpackage

/* File: core/btc_correction_math.sv */
// Summary of operation
// - A2 measures bridge using stored setup word
// - A3 measures bridge using supplied setup word
// - A6 measures temperature using factory setup word
// - A7 measures temperature using supplied setup word
// - Flag intermediate saturation in status bit 0
// - Clamp every overflow to its bound
// - Curve select: 0 parabolic, 1 S-shaped
// - Delta T is raw minus limited reference
// - Gain drift factor from first/second order terms
// - Offset-corrected bridge adds offset and drift term
// - Parabolic intermediate, clamped 0 to 2^17-1
// - Parabolic output, clamped 0 to 2^16-1
// - S-shaped intermediate signed, output non-negative
// - Raw inputs and coefficients are 18-bit signed
// - Temperature always uses parabolic second order
// - Temperature intermediate from offset and gain
// - Corrected temperature, clamped 0 to 2^16-1
//
// Purpose: Command decode, raw measurement request and correction datapath
// Assumes: Converter and coefficient store run on mclk; one step per cycle
// Notes:   Bridge correction uses the latest raw temperature captured
`include "btc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module btc_correction_math
  import btc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              cmdValid,
  input  wire logic [7:0]        cmdCode,
  input  wire logic [15:0]       cmdWord,
  input  wire logic              setupWrEn,
  input  wire logic [7:0]        setupAddr,
  input  wire logic [15:0]       setupWrData,
  input  wire logic [15:0]       tempFactoryConfig,
  input  wire logic              measDone,
  input  wire logic signed [17:0] measRaw,
  input  wire logic              nonlinCurveSelect,
  input  wire logic signed [17:0] lowCalTemperatureRef,
  input  wire logic signed [17:0] gainB,
  input  wire logic signed [17:0] offsetB,
  input  wire logic signed [17:0] tcg,
  input  wire logic signed [17:0] tco,
  input  wire logic signed [17:0] secondOrderGainDrift,
  input  wire logic signed [17:0] secondOrderOffsetDrift,
  input  wire logic signed [17:0] bridgeSecondOrderCoeff,
  input  wire logic signed [17:0] gainT,
  input  wire logic signed [17:0] offsetT,
  input  wire logic signed [17:0] temperatureSecondOrderCoeff,
  output logic                   busy,
  output logic                   measStart,
  output logic                   measIsTemp,
  output logic [15:0]            measConfig,
  output logic [15:0]            bridgeMeasurementSetup,
  output logic                   resultValid,
  output logic [15:0]            resultData,
  output logic signed [17:0]     resultRaw,
  output logic                   resultIsTemp,
  output logic [7:0]             resultStatus
);

  localparam int LAT_MAX = 6;

  btc_regs_t st;
  btc_regs_t next_st;

  // Sign-extend an 18-bit operand into the wide working width
  function automatic logic signed [39:0] ext(input logic signed [17:0] x);
    ext = $signed({{22{x[17]}}, x});
  endfunction

  // Product over 2^15 by arithmetic shift of the full product
  function automatic logic signed [39:0] mshr(input logic signed [17:0] a,
                                              input logic signed [17:0] b);
    logic signed [35:0] p;
    p = a * b;
    mshr = $signed({{4{p[35]}}, p}) >>> `BTC_SHIFT;
  endfunction

  // Clamp to [lo, hi]; bit 18 reports that the bound was hit
  function automatic logic [18:0] clip(input logic signed [39:0] v,
                                       input logic signed [39:0] lo,
                                       input logic signed [39:0] hi);
    logic signed [39:0] c;
    c = v;
    if (v > hi)
      c = hi;
    else if (v < lo)
      c = lo;
    clip = {(v > hi) || (v < lo), c[17:0]};
  endfunction

  always_comb
  begin
    logic [18:0]        r;
    logic signed [17:0] a;
    logic signed [17:0] m;
    logic signed [17:0] c;
    logic signed [17:0] az;
    logic signed [17:0] coef;
    logic signed [39:0] o;
    logic               sShape;
    r      = '0;
    a      = '0;
    m      = '0;
    c      = '0;
    az     = '0;
    coef   = '0;
    o      = '0;
    sShape = nonlinCurveSelect && !st.isTemp;
    next_st = st;
    next_st.measStart   = 1'b0;
    next_st.resultValid = 1'b0;
    if (setupWrEn && setupAddr == `BTC_SETUP_ADDR)
      next_st.setup = setupWrData;
    case (st.state)
      BTC_IDLE:
      begin
        if (cmdValid)
        begin
          case (cmdCode)
            `BTC_CMD_BRIDGE_STORED:
            begin
              next_st.measConfig = st.setup;
              next_st.isTemp     = 1'b0;
              next_st.measStart  = 1'b1;
              next_st.state      = BTC_MEAS;
            end
            `BTC_CMD_BRIDGE_GIVEN:
            begin
              next_st.measConfig = cmdWord;
              next_st.isTemp     = 1'b0;
              next_st.measStart  = 1'b1;
              next_st.state      = BTC_MEAS;
            end
            `BTC_CMD_TEMP_FACTORY:
            begin
              next_st.measConfig = tempFactoryConfig;
              next_st.isTemp     = 1'b1;
              next_st.measStart  = 1'b1;
              next_st.state      = BTC_MEAS;
            end
            `BTC_CMD_TEMP_GIVEN:
            begin
              next_st.measConfig = cmdWord;
              next_st.isTemp     = 1'b1;
              next_st.measStart  = 1'b1;
              next_st.state      = BTC_MEAS;
            end
            default:
            begin
              next_st.state = BTC_IDLE;
            end
          endcase
        end
      end
      BTC_MEAS:
      begin
        if (measDone)
        begin
          // Raw value limited to the symmetric 18-bit range
          r = clip(ext(measRaw), -`BTC_S18_MAX, `BTC_S18_MAX);
          next_st.raw = r[17:0];
          next_st.sat = r[18];
          if (st.isTemp)
          begin
            next_st.tempHold = r[17:0];
            next_st.state    = BTC_Z;
          end
          else
            next_st.state = BTC_DT;
        end
      end
      BTC_DT:
      begin
        r = clip(ext(lowCalTemperatureRef), -`BTC_TSET_MAX, `BTC_TSET_MAX);
        a = r[17:0];
        next_st.sat = st.sat | r[18];
        r = clip(ext(st.tempHold) - ext(a), `BTC_S18_MIN, `BTC_S18_MAX);
        next_st.deltaT = r[17:0];
        next_st.sat    = next_st.sat | r[18];
        next_st.state  = BTC_K1;
      end
      BTC_K1:
      begin
        r = clip(mshr(secondOrderGainDrift, st.deltaT), `BTC_S18_MIN, `BTC_S18_MAX);
        a = r[17:0];
        next_st.sat = st.sat | r[18];
        r = clip(ext(a) + ext(tcg), `BTC_S18_MIN, `BTC_S18_MAX);
        a = r[17:0];
        next_st.sat = next_st.sat | r[18];
        r = clip(mshr(st.deltaT, a), `BTC_S18_MIN, `BTC_S18_MAX);
        m = r[17:0];
        next_st.sat = next_st.sat | r[18];
        r = clip(`BTC_HALF + ext(m), `BTC_S18_MIN, `BTC_S18_MAX);
        next_st.gainDriftFactor = r[17:0];
        next_st.sat   = next_st.sat | r[18];
        next_st.state = BTC_K2;
      end
      BTC_K2:
      begin
        r = clip(mshr(secondOrderOffsetDrift, st.deltaT), `BTC_S18_MIN, `BTC_S18_MAX);
        a = r[17:0];
        next_st.sat = st.sat | r[18];
        r = clip(ext(a) + ext(tco), `BTC_S18_MIN, `BTC_S18_MAX);
        a = r[17:0];
        next_st.sat = next_st.sat | r[18];
        r = clip(mshr(st.deltaT, a), `BTC_S18_MIN, `BTC_S18_MAX);
        m = r[17:0];
        next_st.sat = next_st.sat | r[18];
        r = clip(ext(st.raw) + ext(m), `BTC_S18_MIN, `BTC_S18_MAX);
        m = r[17:0];
        next_st.sat = next_st.sat | r[18];
        r = clip(ext(offsetB) + ext(m), `BTC_S18_MIN, `BTC_S18_MAX);
        next_st.offsetCorrectedBridge = r[17:0];
        next_st.sat   = next_st.sat | r[18];
        next_st.state = BTC_Z;
      end
      BTC_Z:
      begin
        if (st.isTemp)
        begin
          r = clip(ext(st.raw) + ext(offsetT), `BTC_S18_MIN, `BTC_S18_MAX);
          m = r[17:0];
          next_st.sat = st.sat | r[18];
          r = clip(mshr(gainT, m), `BTC_S18_MIN, `BTC_S18_MAX);
        end
        else
        begin
          r = clip(mshr(st.gainDriftFactor, st.offsetCorrectedBridge),
                   `BTC_S18_MIN, `BTC_S18_MAX);
          m = r[17:0];
          next_st.sat = st.sat | r[18];
          r = clip(mshr(gainB, m), `BTC_S18_MIN, `BTC_S18_MAX);
        end
        m = r[17:0];
        next_st.sat = next_st.sat | r[18];
        if (sShape)
          next_st.interm = m;
        else
        begin
          // Parabolic forms are lifted by 2^15 and kept positive
          r = clip(ext(m) + `BTC_HALF, `BTC_ZERO, `BTC_S18_MAX);
          next_st.interm = r[17:0];
          next_st.sat    = next_st.sat | r[18];
        end
        next_st.state = BTC_OUT;
      end
      BTC_OUT:
      begin
        coef = st.isTemp ? temperatureSecondOrderCoeff : bridgeSecondOrderCoeff;
        az   = st.interm;
        if (sShape && st.interm[17])
        begin
          // The most negative value has no positive twin, so it clamps
          r  = clip(-ext(st.interm), `BTC_S18_MIN, `BTC_S18_MAX);
          az = r[17:0];
          next_st.sat = st.sat | r[18];
        end
        r = clip(mshr(coef, az), `BTC_S18_MIN, `BTC_S18_MAX);
        c = r[17:0];
        next_st.sat = next_st.sat | r[18];
        r = clip(ext(c) + `BTC_HALF, `BTC_S18_MIN, `BTC_S18_MAX);
        c = r[17:0];
        next_st.sat = next_st.sat | r[18];
        o = mshr(st.interm, c);
        if (sShape)
        begin
          r = clip(o, `BTC_S18_MIN, `BTC_S18_MAX);
          next_st.sat = next_st.sat | r[18];
          r = clip(ext(r[17:0]) + `BTC_HALF, `BTC_ZERO, `BTC_S18_MAX);
          next_st.sat = next_st.sat | r[18];
          o = ext(r[17:0]);
        end
        r = clip(o, `BTC_ZERO, `BTC_U16_MAX);
        next_st.sat          = next_st.sat | r[18];
        next_st.resultData   = r[15:0];
        next_st.resultRaw    = st.raw;
        next_st.resultIsTemp = st.isTemp;
        next_st.resultStatus = 8'h00;
        // Result still delivered; saturation only reported
        next_st.resultStatus[`BTC_STATUS_SAT_BIT] = next_st.sat;
        next_st.resultValid  = 1'b1;
        next_st.state        = BTC_IDLE;
      end
      default:
      begin
        next_st.state = BTC_IDLE;
      end
    endcase
    // Registered so the flag leaves a flip-flop directly
    next_st.busy = (next_st.state != BTC_IDLE);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st       <= '0;
      st.state <= BTC_IDLE;
      st.setup <= `BTC_SETUP_RESET;
    end
    else
      st <= next_st;
  end

  assign busy                   = st.busy;
  assign measStart              = st.measStart;
  assign measIsTemp             = st.isTemp;
  assign measConfig             = st.measConfig;
  assign bridgeMeasurementSetup = st.setup;
  assign resultValid            = st.resultValid;
  assign resultData             = st.resultData;
  assign resultRaw              = st.resultRaw;
  assign resultIsTemp           = st.resultIsTemp;
  assign resultStatus           = st.resultStatus;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_stored_bridge;
    (st.state == BTC_IDLE) && cmdValid && cmdCode == `BTC_CMD_BRIDGE_STORED
      |=> measStart && !measIsTemp && measConfig == $past(st.setup);
  endproperty
  a_stored_bridge: assert property (p_stored_bridge)
    else $error("stored bridge setup not used");

  property p_given_bridge;
    (st.state == BTC_IDLE) && cmdValid && cmdCode == `BTC_CMD_BRIDGE_GIVEN
      |=> measStart && !measIsTemp && measConfig == $past(cmdWord);
  endproperty
  a_given_bridge: assert property (p_given_bridge)
    else $error("supplied bridge setup not used");

  property p_factory_temp;
    (st.state == BTC_IDLE) && cmdValid && cmdCode == `BTC_CMD_TEMP_FACTORY
      |=> measStart && measIsTemp && measConfig == $past(tempFactoryConfig);
  endproperty
  a_factory_temp: assert property (p_factory_temp)
    else $error("factory temperature setup not used");

  property p_given_temp;
    (st.state == BTC_IDLE) && cmdValid && cmdCode == `BTC_CMD_TEMP_GIVEN
      |=> measStart && measIsTemp && measConfig == $past(cmdWord);
  endproperty
  a_given_temp: assert property (p_given_temp)
    else $error("supplied temperature setup not used");

  property p_result_follows;
    (st.state == BTC_MEAS) && measDone |-> ##[1:LAT_MAX] resultValid;
  endproperty
  a_result_follows: assert property (p_result_follows)
    else $error("no result after measurement");

  property p_sat_cleared;
    (st.state == BTC_MEAS) && measDone && measRaw != 18'sh20000 |=> !st.sat;
  endproperty
  a_sat_cleared: assert property (p_sat_cleared)
    else $error("saturation not cleared at new correction");

  property p_busy_ignores;
    busy && cmdValid |=> !measStart;
  endproperty
  a_busy_ignores: assert property (p_busy_ignores)
    else $error("command taken while busy");

  property p_temp_path;
    (st.state == BTC_MEAS) && measDone && st.isTemp |=> ##2 resultValid && resultIsTemp;
  endproperty
  a_temp_path: assert property (p_temp_path)
    else $error("temperature correction path length wrong");

endmodule

`default_nettype wire

/* File: tb/btc_conv_model.sv */
// Purpose: Converter stand-in answering raw measurement requests
// Assumes: One request per measStart pulse, answered after a set delay
// Notes:   Data line shows the inverse of the last value outside the done pulse
`timescale 1ns/1ps
`default_nettype none

module btc_conv_model (
  input  wire logic               mclk,
  input  wire logic               measStart,
  input  wire logic signed [17:0] rawValue,
  input  wire logic [3:0]         delay,
  output var  logic               measDone,
  output var  logic signed [17:0] measRaw
);
  initial
  begin
    measDone = 1'b0;
    measRaw  = 18'sh00000;
  end

  always @(posedge mclk)
    if (measStart === 1'b1)
    begin
      repeat (delay) @(posedge mclk);
      measDone <= 1'b1;
      measRaw  <= rawValue;
      @(posedge mclk);
      measDone <= 1'b0;
      // Stale data must not look valid
      measRaw  <= ~rawValue;
    end
endmodule
`default_nettype wire

/* File: tb/bridge_temp_correction_math_bench.sv */
// Purpose: Self-checking bench of the correction datapath
// Assumes: Expected values come from an independent clamp-by-step model
// Notes:   Temperature runs first so the bridge path sees a known raw temperature
`include "btc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module bridge_temp_correction_math_bench;
  typedef struct {
    logic [7:0]         code;
    logic [15:0]        word;
    logic signed [17:0] raw;
    logic               curve;
    logic [3:0]         dly;
    logic [15:0]        cfg;
  } btc_row_t;

  logic               mclk = 1'b0;
  logic               reset = 1'b1;
  logic               cmdValid = 1'b0;
  logic [7:0]         cmdCode = 8'h00;
  logic [15:0]        cmdWord = 16'h0000;
  logic               setupWrEn = 1'b0;
  logic [7:0]         setupAddr = 8'h00;
  logic [15:0]        setupWrData = 16'h0000;
  logic [15:0]        tempFactoryConfig = 16'h5A5A;
  logic               measDone;
  logic signed [17:0] measRaw;
  logic               nonlinCurveSelect = 1'b0;
  logic signed [17:0] lowCalTemperatureRef = 18'sh00800;
  logic signed [17:0] gainB = 18'sh0A000;
  logic signed [17:0] offsetB = -18'sh00400;
  logic signed [17:0] tcg = 18'sh01000;
  logic signed [17:0] tco = 18'sh00200;
  logic signed [17:0] secondOrderGainDrift = 18'sh00800;
  logic signed [17:0] secondOrderOffsetDrift = -18'sh00100;
  logic signed [17:0] bridgeSecondOrderCoeff = 18'sh00400;
  logic signed [17:0] gainT = 18'sh09000;
  logic signed [17:0] offsetT = 18'sh00100;
  logic signed [17:0] temperatureSecondOrderCoeff = -18'sh00200;
  logic               busy, measStart, measIsTemp, resultValid, resultIsTemp;
  logic [15:0]        measConfig, bridgeMeasurementSetup, resultData;
  logic signed [17:0] resultRaw;
  logic [7:0]         resultStatus;
  logic signed [17:0] convRaw = 18'sh00000;
  logic [3:0]         convDelay = 4'h0;
  int                 errors = 0;
  int                 total_checks = 0;
  int                 cycles = 0;
  int                 starts = 0;
  int                 s0;
  logic               refSat;
  longint             lastT = 0;
  longint             lastRaw = 0;
  btc_row_t           rows[6] = '{
    '{`BTC_CMD_TEMP_FACTORY, 16'h0000, 18'sh04000, 1'b0, 4'h0, 16'h5A5A},
    '{`BTC_CMD_TEMP_GIVEN, 16'h1234, 18'sh0C000, 1'b0, 4'h3, 16'h1234},
    '{`BTC_CMD_BRIDGE_STORED, 16'h0000, 18'sh10000, 1'b0, 4'h7, 16'hC3C3},
    '{`BTC_CMD_BRIDGE_GIVEN, 16'h0F0F, -18'sh08000, 1'b1, 4'h1, 16'h0F0F},
    '{`BTC_CMD_BRIDGE_STORED, 16'h0000, 18'sh1F000, 1'b1, 4'h0, 16'hC3C3},
    '{`BTC_CMD_BRIDGE_GIVEN, 16'hA5A5, 18'sh1FFFF, 1'b0, 4'h2, 16'hA5A5}};

  btc_correction_math btc_correction_math_i (
    .mclk                        (mclk),
    .reset                       (reset),
    .cmdValid                    (cmdValid),
    .cmdCode                     (cmdCode),
    .cmdWord                     (cmdWord),
    .setupWrEn                   (setupWrEn),
    .setupAddr                   (setupAddr),
    .setupWrData                 (setupWrData),
    .tempFactoryConfig           (tempFactoryConfig),
    .measDone                    (measDone),
    .measRaw                     (measRaw),
    .nonlinCurveSelect           (nonlinCurveSelect),
    .lowCalTemperatureRef        (lowCalTemperatureRef),
    .gainB                       (gainB),
    .offsetB                     (offsetB),
    .tcg                         (tcg),
    .tco                         (tco),
    .secondOrderGainDrift        (secondOrderGainDrift),
    .secondOrderOffsetDrift      (secondOrderOffsetDrift),
    .bridgeSecondOrderCoeff      (bridgeSecondOrderCoeff),
    .gainT                       (gainT),
    .offsetT                     (offsetT),
    .temperatureSecondOrderCoeff (temperatureSecondOrderCoeff),
    .busy                        (busy),
    .measStart                   (measStart),
    .measIsTemp                  (measIsTemp),
    .measConfig                  (measConfig),
    .bridgeMeasurementSetup      (bridgeMeasurementSetup),
    .resultValid                 (resultValid),
    .resultData                  (resultData),
    .resultRaw                   (resultRaw),
    .resultIsTemp                (resultIsTemp),
    .resultStatus                (resultStatus)
  );

  btc_conv_model btc_conv_model_i (
    .mclk      (mclk),
    .measStart (measStart),
    .rawValue  (convRaw),
    .delay     (convDelay),
    .measDone  (measDone),
    .measRaw   (measRaw)
  );

  always #25 mclk = ~mclk;

  always @(posedge mclk)
  begin
    cycles++;
    starts += (measStart === 1'b1);
    if (cycles == 5000)
    begin
      errors++;
      close_out();
    end
  end

  function automatic longint cl(input longint x, input longint lo, input longint hi);
    refSat |= (x > hi) || (x < lo);
    return (x > hi) ? hi : ((x < lo) ? lo : x);
  endfunction

  function automatic longint s(input longint x);
    return cl(x, `BTC_S18_MIN, `BTC_S18_MAX);
  endfunction

  // Product first, then arithmetic shift, so rounding is toward minus infinity
  function automatic longint sh(input longint a, input longint b);
    return (a * b) >>> `BTC_SHIFT;
  endfunction

  function automatic longint tRef(input longint raw);
    longint r, z;
    r = cl(raw, -`BTC_S18_MAX, `BTC_S18_MAX);
    lastT = r;
    lastRaw = r;
    z = cl(s(sh(gainT, s(r + offsetT))) + `BTC_HALF, `BTC_ZERO, `BTC_S18_MAX);
    z = sh(z, s(s(sh(temperatureSecondOrderCoeff, z)) + `BTC_HALF));
    return cl(z, `BTC_ZERO, `BTC_U16_MAX);
  endfunction

  function automatic longint bRef(input longint raw, input logic curve);
    longint b, d, k1, k2, m, z;
    b = cl(raw, -`BTC_S18_MAX, `BTC_S18_MAX);
    lastRaw = b;
    d = s(lastT - cl(lowCalTemperatureRef, -`BTC_TSET_MAX, `BTC_TSET_MAX));
    k1 = s(`BTC_HALF + s(sh(d, s(s(sh(secondOrderGainDrift, d)) + tcg))));
    k2 = s(offsetB + s(b + s(sh(d, s(s(sh(secondOrderOffsetDrift, d)) + tco)))));
    m = s(sh(gainB, s(sh(k1, k2))));
    if (curve)
    begin
      // Magnitude of the most negative value clamps like any other step
      z = s(sh(m, s(s(sh(bridgeSecondOrderCoeff, s((m < 0) ? -m : m))) + `BTC_HALF)));
      z = cl(z + `BTC_HALF, `BTC_ZERO, `BTC_S18_MAX);
      return cl(z, `BTC_ZERO, `BTC_U16_MAX);
    end
    z = cl(m + `BTC_HALF, `BTC_ZERO, `BTC_S18_MAX);
    return cl(sh(z, s(s(sh(bridgeSecondOrderCoeff, z)) + `BTC_HALF)), `BTC_ZERO, `BTC_U16_MAX);
  endfunction

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [15:0] data);
    @(posedge mclk);
    setupWrEn <= 1'b1;
    setupAddr <= addr;
    setupWrData <= data;
    @(posedge mclk);
    setupWrEn <= 1'b0;
    @(negedge mclk);
  endtask

  task automatic run(input logic [7:0] code, input logic [15:0] word,
                     input logic signed [17:0] raw, input logic curve,
                     input logic [3:0] dly, input logic [15:0] cfg);
    logic   isT;
    longint expD;
    logic   expS;
    int     n;
    isT = code[2];
    refSat = 1'b0;
    expD = isT ? tRef(raw) : bRef(raw, curve);
    expS = refSat;
    n = 0;
    @(posedge mclk);
    cmdValid <= 1'b1;
    cmdCode <= code;
    cmdWord <= word;
    nonlinCurveSelect <= curve;
    convRaw <= raw;
    convDelay <= dly;
    @(posedge mclk);
    cmdValid <= 1'b0;
    @(negedge mclk);
    chk(measStart, 1'b1);
    chk(measConfig, cfg);
    chk(measIsTemp, isT);
    chk(busy, 1'b1);
    while (resultValid !== 1'b1 && n < 40) @(negedge mclk) n++;
    chk(resultValid, 1'b1);
    chk(resultData, expD);
    chk(resultStatus, {7'h00, expS});
    chk(resultRaw, lastRaw);
    chk(resultIsTemp, isT);
  endtask

  initial
  begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    chk(busy, 1'b0);
    chk(bridgeMeasurementSetup, `BTC_SETUP_RESET);
    chk(resultValid | measStart, 1'b0);
    wr(8'h11, 16'hFFFF);
    chk(bridgeMeasurementSetup, `BTC_SETUP_RESET);
    // The stored setup word is programmed before any stored-setup command
    wr(`BTC_SETUP_ADDR, 16'hC3C3);
    chk(bridgeMeasurementSetup, 16'hC3C3);
    for (int i = 0; i < 6; i++)
      run(rows[i].code, rows[i].word, rows[i].raw, rows[i].curve, rows[i].dly, rows[i].cfg);
    @(posedge mclk);
    cmdValid <= 1'b1;
    cmdCode <= 8'hA4;
    @(posedge mclk);
    cmdValid <= 1'b0;
    @(negedge mclk);
    chk(measStart | busy, 1'b0);
    s0 = starts;
    // A command while busy is dropped; a setup write is still taken
    fork
      run(`BTC_CMD_TEMP_FACTORY, 16'h0000, 18'sh02000, 1'b0, 4'h6, 16'h5A5A);
      begin
        repeat (3) @(posedge mclk);
        cmdValid <= 1'b1;
        cmdCode <= `BTC_CMD_BRIDGE_GIVEN;
        setupWrEn <= 1'b1;
        setupAddr <= `BTC_SETUP_ADDR;
        setupWrData <= 16'h7E7E;
        @(posedge mclk);
        cmdValid <= 1'b0;
        setupWrEn <= 1'b0;
      end
    join
    repeat (4) @(negedge mclk);
    chk(starts, s0 + 1);
    chk(bridgeMeasurementSetup, 16'h7E7E);
    @(posedge mclk);
    gainT <= 18'sh1FFFF;
    offsetT <= 18'sh1FFFF;
    @(negedge mclk);
    run(`BTC_CMD_TEMP_FACTORY, 16'h0000, 18'sh1FFFF, 1'b0, 4'h1, 16'h5A5A);
    chk(resultStatus[`BTC_STATUS_SAT_BIT], 1'b1);
    @(posedge mclk);
    gainT <= 18'sh09000;
    offsetT <= 18'sh00100;
    @(negedge mclk);
    run(`BTC_CMD_TEMP_GIVEN, 16'h0001, 18'sh01000, 1'b0, 4'h2, 16'h0001);
    chk(resultStatus, 8'h00);
    // Reset in the middle of a measurement drops it and the stored setup
    @(posedge mclk);
    cmdValid <= 1'b1;
    cmdCode <= `BTC_CMD_BRIDGE_STORED;
    @(posedge mclk);
    cmdValid <= 1'b0;
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    chk(busy, 1'b0);
    chk(bridgeMeasurementSetup, `BTC_SETUP_RESET);
    chk(resultValid | measStart, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
